/* File: hdl/abort_err_logger.sv */
// Purpose: abort and unexpected-completion error logging for a bridge
// Assumes: event inputs are one-cycle pulses from same-clock logic
// Notes: status bits are sticky and write-one-to-clear
//
// Overview of operation
// (RQ1) drop target-aborted posted write entirely
// (RQ2) any secondary target-abort sets secondary flag
// (RQ3) request target-abort sets uncorrectable status bit
// (RQ4) unmasked, pointer invalid: log header, set pointer
// (RQ5) unmasked: send message by severity when enabled
// (RQ6) message plus serr enable sets system error
// (RQ7) set fatal or nonfatal detected by severity
// (RQ8) non-posted target-abort returns completer abort
// (RQ9) aborted split completion discarded, flag set
// (RQ10) split completion uses its own error bits
// (RQ11) unsupported request: master abort flag, message
// (RQ12) completer abort: two abort flags, error message
// (RQ13) unexpected: own requester id, no match
// (RQ14) advisory unmasked: correctable message, set flags
// (RQ15) advisory masked: no message, still set flags
// (RQ16) every unexpected completion sets its status bit
// (RQ17) log header only if unmasked, pointer invalid
// (RQ18) non-advisory: fatal detected, maybe fatal message
// (RQ19) fatal message with serr enable sets flag
// (RQ20) own secondary id, no tag: split flag
// (RQ21) flags stay set until software clears
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "abort_err_params.svh"
module abort_err_logger #(
    parameter int HDR_W = 32
) (
    // clock, reset, enable
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic CE_IN,
    // secondary bus events
    input wire abort_err_pkg::sec_event_t SEC_EVENT_IN,
    input wire logic [HDR_W-1:0] SEC_HDR_IN,
    input wire logic [4:0] SEC_PTR_IN,
    // pcie completion events
    input wire logic CPL_VALID_IN,
    input wire logic [2:0] CPL_STATUS_IN,
    input wire abort_err_pkg::req_id_t CPL_REQ_ID_IN,
    input wire logic CPL_MATCH_IN,
    input wire logic CPL_TAG_OWNED_IN,
    input wire logic [HDR_W-1:0] CPL_HDR_IN,
    input wire abort_err_pkg::req_id_t OWN_ID_IN,
    input wire logic [7:0] SEC_BUS_IN,
    // actions
    output logic DROP_TXN_OUT,
    output logic CA_CPL_OUT,
    output logic SPLIT_MSG_OUT,
    output logic SPLIT_ERR_MSG_OUT,
    output var abort_err_pkg::err_msg_t MSG_OUT,
    // axi4-lite slave
    input wire logic [7:0] AWADDR_IN,
    input wire logic AWVALID_IN,
    output logic AWREADY_OUT,
    input wire logic [31:0] WDATA_IN,
    input wire logic [3:0] WSTRB_IN,
    input wire logic WVALID_IN,
    output logic WREADY_OUT,
    output logic [1:0] BRESP_OUT,
    output logic BVALID_OUT,
    input wire logic BREADY_IN,
    input wire logic [7:0] ARADDR_IN,
    input wire logic ARVALID_IN,
    output logic ARREADY_OUT,
    output logic [31:0] RDATA_OUT,
    output logic [1:0] RRESP_OUT,
    output logic RVALID_OUT,
    input wire logic RREADY_IN
);
    localparam logic [2:0] CS_UR = 3'h1;
    localparam logic [2:0] CS_CA = 3'h4;

    logic [3:0] ctrl;
    logic [3:0] sev;
    logic [3:0] mask;
    logic [`STAT_W-1:0] stat;
    logic [HDR_W-1:0] hdr_log;
    logic [4:0] first_error_pointer;
    logic ptr_valid;

    // per-event decode
    logic sec_ta, req_ta, split_ta;
    logic [1:0] eidx;
    logic sec_unmasked, sec_fatal, sec_send;
    logic unexp, advisory, unexp_send, cor_send, px_unexp;
    logic [`STAT_W-1:0] set_bits, clr_bits;
    logic do_log_sec, do_log_unexp;

    always_comb
    begin
        sec_ta = (SEC_EVENT_IN != abort_err_pkg::EV_NONE); // see (RQ2)
        req_ta = (SEC_EVENT_IN == abort_err_pkg::EV_POSTED_TA)
            || (SEC_EVENT_IN == abort_err_pkg::EV_NP_TA);
        split_ta = (SEC_EVENT_IN == abort_err_pkg::EV_SPLIT_TA);
        eidx = split_ta ? 2'(`EI_TASC) : 2'(`EI_RTA); // see (RQ10)
        sec_unmasked = sec_ta && !mask[eidx];
        sec_fatal = sev[eidx];
        sec_send = sec_unmasked && (ctrl[`CTL_SERR]
            || (sec_fatal ? ctrl[`CTL_FTL] : ctrl[`CTL_NFTL])); // see (RQ5)
        unexp = CPL_VALID_IN && (CPL_REQ_ID_IN == OWN_ID_IN) && !CPL_MATCH_IN; // see (RQ13)
        advisory = !sev[`EI_UNEXP];
        cor_send = unexp && advisory && !mask[`EI_ADV] && ctrl[`CTL_COR]; // see (RQ14)
        unexp_send = unexp && !advisory && !mask[`EI_UNEXP]
            && (ctrl[`CTL_SERR] || ctrl[`CTL_FTL]); // see (RQ18)
        px_unexp = CPL_VALID_IN && (CPL_REQ_ID_IN.bus == SEC_BUS_IN)
            && (CPL_REQ_ID_IN.dev == 5'h0_0) && (CPL_REQ_ID_IN.func == 3'h0)
            && !CPL_TAG_OWNED_IN; // see (RQ20)
        do_log_sec = sec_unmasked && !ptr_valid; // see (RQ4)
        do_log_unexp = unexp && !mask[`EI_UNEXP] && !ptr_valid && !do_log_sec; // see (RQ17)
        set_bits = '0;
        set_bits[`ST_SEC_RTA] = sec_ta; // see (RQ2)
        set_bits[`ST_UNC_RTA] = req_ta; // see (RQ3)
        set_bits[`ST_UNC_TASC] = split_ta; // see (RQ10)
        set_bits[`ST_SPLIT_DISC] = split_ta; // see (RQ9)
        set_bits[`ST_PRI_RMA] = CPL_VALID_IN && CPL_STATUS_IN == CS_UR; // see (RQ11)
        set_bits[`ST_PRI_RTA] = CPL_VALID_IN && CPL_STATUS_IN == CS_CA; // see (RQ12)
        set_bits[`ST_SEC_STA] = CPL_VALID_IN && CPL_STATUS_IN == CS_CA; // see (RQ12)
        set_bits[`ST_SSERR] = ctrl[`CTL_SERR] && (sec_send || unexp_send); // see (RQ6) (RQ19)
        set_bits[`ST_FTL_DTD] = (sec_ta && sec_fatal) || (unexp && !advisory); // see (RQ7) (RQ18)
        set_bits[`ST_NFTL_DTD] = sec_ta && !sec_fatal; // see (RQ7)
        set_bits[`ST_COR_DTD] = unexp && advisory; // see (RQ14) (RQ15)
        set_bits[`ST_ADV] = unexp && advisory; // see (RQ15)
        set_bits[`ST_UNEXP] = unexp; // see (RQ16)
        set_bits[`ST_PX_UNEXP] = px_unexp; // see (RQ20)
    end

    // actions toward the link and the secondary bus
    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            DROP_TXN_OUT <= 1'b0;
            CA_CPL_OUT <= 1'b0;
            SPLIT_MSG_OUT <= 1'b0;
            SPLIT_ERR_MSG_OUT <= 1'b0;
            MSG_OUT <= '0;
        end
        else if (CE_IN)
        begin
            // posted and split data are both thrown away whole
            DROP_TXN_OUT <= (SEC_EVENT_IN == abort_err_pkg::EV_POSTED_TA) || split_ta; // see (RQ1) (RQ9)
            CA_CPL_OUT <= (SEC_EVENT_IN == abort_err_pkg::EV_NP_TA); // see (RQ8)
            SPLIT_MSG_OUT <= CPL_VALID_IN && CPL_STATUS_IN == CS_UR; // see (RQ11)
            SPLIT_ERR_MSG_OUT <= CPL_VALID_IN && CPL_STATUS_IN == CS_CA; // see (RQ12)
            MSG_OUT.fatal <= (sec_send && sec_fatal) || unexp_send; // see (RQ5) (RQ18)
            MSG_OUT.nonfatal <= sec_send && !sec_fatal; // see (RQ5)
            MSG_OUT.correctable <= cor_send; // see (RQ14)
        end
    end

    // axi4-lite write path; address and data may arrive in either order
    abort_err_pkg::wr_state_t wr_state;
    logic aw_got, w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    assign wr_fire = (wr_state == abort_err_pkg::WR_HOLD);

    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            wr_state <= abort_err_pkg::WR_IDLE;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            AWREADY_OUT <= 1'b0;
            WREADY_OUT <= 1'b0;
            BVALID_OUT <= 1'b0;
            BRESP_OUT <= 2'b00;
        end
        else if (CE_IN)
        begin
            AWREADY_OUT <= 1'b0;
            WREADY_OUT <= 1'b0;
            case (wr_state)
                abort_err_pkg::WR_IDLE:
                begin
                    if (AWVALID_IN && !aw_got && !AWREADY_OUT)
                    begin
                        AWREADY_OUT <= 1'b1;
                        aw_got <= 1'b1;
                        aw_addr <= AWADDR_IN;
                    end
                    if (WVALID_IN && !w_got && !WREADY_OUT)
                    begin
                        WREADY_OUT <= 1'b1;
                        w_got <= 1'b1;
                        w_data <= WDATA_IN;
                        w_strb <= WSTRB_IN;
                    end
                    if (aw_got && w_got)
                        wr_state <= abort_err_pkg::WR_HOLD;
                end
                abort_err_pkg::WR_HOLD:
                begin
                    BVALID_OUT <= 1'b1;
                    BRESP_OUT <= (aw_addr[7:2] <= 6'h05 && aw_addr[1:0] == 2'b00)
                        ? 2'b00 : 2'b10;
                    wr_state <= abort_err_pkg::WR_RESP;
                end
                abort_err_pkg::WR_RESP:
                begin
                    if (BREADY_IN)
                    begin
                        BVALID_OUT <= 1'b0;
                        aw_got <= 1'b0;
                        w_got <= 1'b0;
                        wr_state <= abort_err_pkg::WR_IDLE;
                    end
                end
                default:
                    wr_state <= abort_err_pkg::WR_IDLE;
            endcase
        end
    end

    // control registers; only byte 0 carries bits
    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            ctrl <= 4'h0;
            sev <= 4'h0;
            mask <= 4'h0;
        end
        else if (CE_IN && wr_fire && w_strb[0])
        begin
            if (aw_addr == `REG_CTRL)
                ctrl <= w_data[3:0];
            if (aw_addr == `REG_SEV)
                sev <= w_data[3:0];
            if (aw_addr == `REG_MASK)
                mask <= w_data[3:0];
        end
    end

    // sticky status, write one to clear; a new set wins over the clear
    always_comb
    begin
        clr_bits = '0;
        if (wr_fire && aw_addr == `REG_STAT)
            clr_bits = w_data[`STAT_W-1:0] & {{(`STAT_W-8){w_strb[1]}}, {8{w_strb[0]}}};
    end

    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
            stat <= '0;
        else if (CE_IN)
            stat <= (stat & ~clr_bits) | set_bits; // see (RQ21)
    end

    // first error header and pointer; writing the pointer register rearms it
    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            hdr_log <= '0;
            first_error_pointer <= `PTR_NONE;
            ptr_valid <= 1'b0;
        end
        else if (CE_IN)
        begin
            if (do_log_sec)
            begin
                hdr_log <= SEC_HDR_IN; // see (RQ4)
                first_error_pointer <= split_ta ? 5'(`EI_TASC) : 5'(`EI_RTA);
                ptr_valid <= 1'b1;
            end
            else if (do_log_unexp)
            begin
                hdr_log <= CPL_HDR_IN; // see (RQ17)
                first_error_pointer <= 5'(`EI_UNEXP);
                ptr_valid <= 1'b1;
            end
            else if (wr_fire && aw_addr == `REG_PTR && w_strb[0])
            begin
                first_error_pointer <= `PTR_NONE;
                ptr_valid <= 1'b0;
            end
        end
    end

    // axi4-lite read path, address accept and data in the same cycle
    logic [31:0] rd_mux;
    always_comb
    begin
        case (ARADDR_IN)
            `REG_CTRL: rd_mux = {28'h000_0000, ctrl};
            `REG_SEV: rd_mux = {28'h000_0000, sev};
            `REG_MASK: rd_mux = {28'h000_0000, mask};
            `REG_STAT: rd_mux = {{(32-`STAT_W){1'b0}}, stat};
            `REG_HDR: rd_mux = 32'(hdr_log);
            `REG_PTR: rd_mux = {26'h000_0000, ptr_valid, first_error_pointer};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            ARREADY_OUT <= 1'b0;
            RVALID_OUT <= 1'b0;
            RDATA_OUT <= 32'h0000_0000;
            RRESP_OUT <= 2'b00;
        end
        else if (CE_IN)
        begin
            ARREADY_OUT <= 1'b0;
            if (RVALID_OUT)
            begin
                if (RREADY_IN)
                    RVALID_OUT <= 1'b0;
            end
            else if (ARVALID_IN && !ARREADY_OUT)
            begin
                ARREADY_OUT <= 1'b1;
                RVALID_OUT <= 1'b1;
                RDATA_OUT <= rd_mux;
                RRESP_OUT <= (ARADDR_IN <= `REG_PTR && ARADDR_IN[1:0] == 2'b00)
                    ? 2'b00 : 2'b10;
            end
        end
    end

    // checks
    property p_posted_drop;
        @(posedge CLK_IN) disable iff (RST_IN)
        (CE_IN && SEC_EVENT_IN == abort_err_pkg::EV_POSTED_TA) |=> DROP_TXN_OUT;
    endproperty
    a_posted_drop: assert property (p_posted_drop) else $error("posted abort not dropped"); // see (RQ1)

    property p_sec_flag;
        @(posedge CLK_IN) disable iff (RST_IN)
        (CE_IN && sec_ta) |=> stat[`ST_SEC_RTA];
    endproperty
    a_sec_flag: assert property (p_sec_flag) else $error("secondary abort flag missing"); // see (RQ2)

    property p_np_ca;
        @(posedge CLK_IN) disable iff (RST_IN)
        (CE_IN && SEC_EVENT_IN == abort_err_pkg::EV_NP_TA) |=> CA_CPL_OUT && !DROP_TXN_OUT;
    endproperty
    a_np_ca: assert property (p_np_ca) else $error("no completer abort"); // see (RQ8)

    property p_split;
        @(posedge CLK_IN) disable iff (RST_IN)
        (CE_IN && split_ta) |=> stat[`ST_SPLIT_DISC] && stat[`ST_UNC_TASC];
    endproperty
    a_split: assert property (p_split) else $error("split abort flags missing"); // see (RQ9)

    property p_log_once;
        @(posedge CLK_IN) disable iff (RST_IN)
        (CE_IN && ptr_valid && !(wr_fire && aw_addr == `REG_PTR)) |=> $stable(hdr_log);
    endproperty
    a_log_once: assert property (p_log_once) else $error("header overwritten"); // see (RQ4)

    property p_masked_quiet;
        @(posedge CLK_IN) disable iff (RST_IN)
        (CE_IN && sec_ta && mask[eidx] && !unexp) |=> !MSG_OUT.fatal && !MSG_OUT.nonfatal;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("masked error sent"); // see (RQ5)

    property p_unexp_stat;
        @(posedge CLK_IN) disable iff (RST_IN)
        (CE_IN && unexp) |=> stat[`ST_UNEXP];
    endproperty
    a_unexp_stat: assert property (p_unexp_stat) else $error("unexpected bit missing"); // see (RQ16)

    property p_sticky;
        @(posedge CLK_IN) disable iff (RST_IN)
        (stat[`ST_FTL_DTD] && !(wr_fire && aw_addr == `REG_STAT)) |=> stat[`ST_FTL_DTD];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost"); // see (RQ21)

    // completion status answers: the request is seen, then flags and message follow
    sequence s_ur_cpl;
        CE_IN && CPL_VALID_IN && CPL_STATUS_IN == CS_UR;
    endsequence
    sequence s_ca_cpl;
        CE_IN && CPL_VALID_IN && CPL_STATUS_IN == CS_CA;
    endsequence
    property p_ur_cpl;
        @(posedge CLK_IN) disable iff (RST_IN)
        s_ur_cpl |=> SPLIT_MSG_OUT && stat[`ST_PRI_RMA];
    endproperty
    a_ur_cpl: assert property (p_ur_cpl) else $error("unsupported request not handled"); // see (RQ11)
    property p_ca_cpl;
        @(posedge CLK_IN) disable iff (RST_IN)
        s_ca_cpl |=> SPLIT_ERR_MSG_OUT && stat[`ST_PRI_RTA] && stat[`ST_SEC_STA];
    endproperty
    a_ca_cpl: assert property (p_ca_cpl) else $error("completer abort not handled"); // see (RQ12)
endmodule
`default_nettype wire

/* File: hdl/abort_err_params.svh */
// Purpose: constants for the abort and unexpected-completion error logger
// Assumes: AXI4-Lite register map, 32-bit data
// Notes: all offsets are byte addresses
`ifndef ABORT_ERR_PARAMS_SVH
`define ABORT_ERR_PARAMS_SVH
`define REG_CTRL 8'h00
`define REG_SEV 8'h04
`define REG_MASK 8'h08
`define REG_STAT 8'h0C
`define REG_HDR 8'h10
`define REG_PTR 8'h14
// control bits
`define CTL_SERR 0
`define CTL_FTL 1
`define CTL_NFTL 2
`define CTL_COR 3
// error index bits used in severity, mask and the first error pointer; EI_ADV is used in the mask only
`define EI_RTA 0
`define EI_TASC 1
`define EI_UNEXP 2
`define EI_ADV 3
// status bits
`define ST_SEC_RTA 0
`define ST_UNC_RTA 1
`define ST_UNC_TASC 2
`define ST_SPLIT_DISC 3
`define ST_PRI_RMA 4
`define ST_PRI_RTA 5
`define ST_SEC_STA 6
`define ST_SSERR 7
`define ST_FTL_DTD 8
`define ST_NFTL_DTD 9
`define ST_COR_DTD 10
`define ST_ADV 11
`define ST_UNEXP 12
`define ST_PX_UNEXP 13
`define STAT_W 14
`define PTR_NONE 5'h1F
`endif

/* File: hdl/abort_err_pkg.sv */
// Purpose: types for the abort and unexpected-completion error logger
// Assumes: constants come from the params header
// Notes: none
package abort_err_pkg;
    typedef enum logic [3:0] {
        EV_NONE = 4'b0001,
        EV_POSTED_TA = 4'b0010,
        EV_NP_TA = 4'b0100,
        EV_SPLIT_TA = 4'b1000
    } sec_event_t;
    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_RESP = 3'b010,
        WR_HOLD = 3'b100
    } wr_state_t;
    typedef struct packed {
        logic fatal;
        logic nonfatal;
        logic correctable;
    } err_msg_t;
    typedef struct packed {
        logic [7:0] bus;
        logic [4:0] dev;
        logic [2:0] func;
    } req_id_t;
endpackage

/* File: tb/far_side_model.sv */
// Purpose: far-side model raising secondary aborts and pcie completions
// Assumes: called from the bench just after a rising edge
// Notes: released header lines show inverted data so a stale value never matches
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
    // clock
    input wire logic clk_in,
    // secondary bus side
    output var abort_err_pkg::sec_event_t sec_event_out,
    output logic [31:0] sec_hdr_out,
    // pcie completion side
    output logic cpl_valid_out,
    output logic [2:0] cpl_status_out,
    output var abort_err_pkg::req_id_t cpl_req_id_out,
    output logic cpl_match_out,
    output logic cpl_owned_out,
    output logic [31:0] cpl_hdr_out
);
    initial
    begin
        sec_event_out = abort_err_pkg::EV_NONE;
        sec_hdr_out = 32'h0000_0000;
        cpl_valid_out = 1'b0;
        cpl_status_out = 3'h0;
        cpl_req_id_out = 16'h0000;
        cpl_match_out = 1'b1;
        cpl_owned_out = 1'b1;
        cpl_hdr_out = 32'h0000_0000;
    end
    task automatic abort(input abort_err_pkg::sec_event_t kind, input logic [31:0] hdr);
        @(posedge clk_in);
        sec_event_out <= kind;
        sec_hdr_out <= hdr;
        @(posedge clk_in);
        sec_event_out <= abort_err_pkg::EV_NONE;
        sec_hdr_out <= ~hdr;
    endtask
    task automatic complete(input logic [2:0] st, input abort_err_pkg::req_id_t id,
        input logic match, input logic owned, input logic [31:0] hdr);
        @(posedge clk_in);
        cpl_valid_out <= 1'b1;
        cpl_status_out <= st;
        cpl_req_id_out <= id;
        cpl_match_out <= match;
        cpl_owned_out <= owned;
        cpl_hdr_out <= hdr;
        @(posedge clk_in);
        cpl_valid_out <= 1'b0;
        cpl_status_out <= ~st;
        cpl_req_id_out <= ~id;
        cpl_match_out <= ~match;
        cpl_owned_out <= ~owned;
        cpl_hdr_out <= ~hdr;
    endtask
endmodule
`default_nettype wire

/* File: tb/bridge_abort_error_reporting_tb.sv */
// Purpose: self-checking bench for the abort and unexpected-completion logger
// Assumes: far_side_model raises every event, the bench is the register master
// Notes: action pulses are scored from a queue; status is read after each table event
`timescale 1ns/1ps
`default_nettype none
`include "abort_err_params.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_total++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module bridge_abort_error_reporting_tb;
    typedef struct packed {
        logic [3:0] ctrl;
        logic [3:0] sev;
        logic [3:0] mask;
        logic [3:0] kind;
        logic [6:0] act;
        logic [13:0] st;
    } row_t;
    // columns: ctrl, severity, mask, event kind, actions, status
    row_t tbl [17] = '{
        '{4'hF, 4'h0, 4'h0, 4'h0, 7'h42, 14'h0283},
        '{4'hF, 4'h0, 4'h0, 4'h1, 7'h22, 14'h0283},
        '{4'hF, 4'h2, 4'h0, 4'h2, 7'h44, 14'h018D},
        '{4'hF, 4'h1, 4'h0, 4'h2, 7'h42, 14'h028D},
        '{4'hF, 4'h0, 4'h2, 4'h2, 7'h40, 14'h020D},
        '{4'hF, 4'h0, 4'h1, 4'h0, 7'h40, 14'h0203},
        '{4'h0, 4'h0, 4'h0, 4'h0, 7'h40, 14'h0203},
        '{4'h2, 4'h1, 4'h0, 4'h0, 7'h44, 14'h0103},
        '{4'h4, 4'h1, 4'h0, 4'h1, 7'h20, 14'h0103},
        '{4'h1, 4'h0, 4'h0, 4'h1, 7'h22, 14'h0283},
        '{4'hF, 4'h0, 4'h0, 4'h3, 7'h10, 14'h0010},
        '{4'hF, 4'h0, 4'h0, 4'h4, 7'h08, 14'h0060},
        '{4'h8, 4'h0, 4'h0, 4'h5, 7'h01, 14'h3C00},
        '{4'hF, 4'h0, 4'h8, 4'h5, 7'h00, 14'h3C00},
        '{4'h1, 4'h4, 4'h0, 4'h6, 7'h04, 14'h1180},
        '{4'hF, 4'h4, 4'h4, 4'h5, 7'h00, 14'h3100},
        '{4'hF, 4'h0, 4'h0, 4'h7, 7'h00, 14'h0000}
    };
    int err_total = 0;
    int num_checks = 0;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic ce = 1'b1;
    logic [6:0] exp_act;
    logic awready, wready, bvalid, arready, rvalid, drop, ca, smsg, serr;
    logic cpl_valid, cpl_match, cpl_owned;
    logic [1:0] bresp, rresp, rd_resp, wr_resp;
    logic [2:0] cpl_status;
    logic [31:0] rdata, rd_val, sec_hdr, cpl_hdr, h1, h2;
    logic [6:0] expq [$];
    abort_err_pkg::err_msg_t msg;
    abort_err_pkg::sec_event_t sec_event;
    abort_err_pkg::req_id_t cpl_req_id;
    // own id sits on the secondary bus with device and function zero
    abort_err_pkg::req_id_t own_id = 16'h5A00;
    wire logic [6:0] acts;
    assign acts = {drop, ca, smsg, serr, msg};
    always #25 clk = ~clk;
    far_side_model u_far (.clk_in(clk), .sec_event_out(sec_event), .sec_hdr_out(sec_hdr),
        .cpl_valid_out(cpl_valid), .cpl_status_out(cpl_status), .cpl_req_id_out(cpl_req_id),
        .cpl_match_out(cpl_match), .cpl_owned_out(cpl_owned), .cpl_hdr_out(cpl_hdr));
    abort_err_logger u_abort_err_logger (.CLK_IN(clk), .RST_IN(rst), .CE_IN(ce),
        .SEC_EVENT_IN(sec_event), .SEC_HDR_IN(sec_hdr), .SEC_PTR_IN(5'h00),
        .CPL_VALID_IN(cpl_valid), .CPL_STATUS_IN(cpl_status), .CPL_REQ_ID_IN(cpl_req_id),
        .CPL_MATCH_IN(cpl_match), .CPL_TAG_OWNED_IN(cpl_owned), .CPL_HDR_IN(cpl_hdr),
        .OWN_ID_IN(own_id), .SEC_BUS_IN(8'h5A), .DROP_TXN_OUT(drop), .CA_CPL_OUT(ca),
        .SPLIT_MSG_OUT(smsg), .SPLIT_ERR_MSG_OUT(serr), .MSG_OUT(msg),
        .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .WDATA_IN(wdata),
        .WSTRB_IN(wstrb), .WVALID_IN(wvalid), .WREADY_OUT(wready), .BRESP_OUT(bresp),
        .BVALID_OUT(bvalid), .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid),
        .ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid),
        .RREADY_IN(rready));
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        wr_resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        rd_val = rdata;
        rd_resp = rresp;
        rready <= 1'b0;
    endtask
    // the expected actions are noted before the event is launched
    task automatic fire(input logic [3:0] k, input logic [6:0] o, input logic [31:0] h);
        if (o !== 7'h00)
            expq.push_back(o);
        case (k)
            4'h0: u_far.abort(abort_err_pkg::EV_POSTED_TA, h);
            4'h1: u_far.abort(abort_err_pkg::EV_NP_TA, h);
            4'h2: u_far.abort(abort_err_pkg::EV_SPLIT_TA, h);
            4'h3: u_far.complete(3'h1, own_id, 1'b1, 1'b1, h);
            4'h4: u_far.complete(3'h4, own_id, 1'b1, 1'b1, h);
            4'h5: u_far.complete(3'h0, own_id, 1'b0, 1'b0, h);
            4'h6: u_far.complete(3'h0, own_id, 1'b0, 1'b1, h);
            default: u_far.complete(3'h0, 16'h3309, 1'b0, 1'b0, h);
        endcase
    endtask
    always @(posedge clk)
    begin
        if (!rst && acts !== 7'h00)
        begin
            if (expq.size() == 0)
                `CHK("unexpected actions", 7'h00, acts)
            else
            begin
                // pop once: the compare macro names its expected value twice
                exp_act = expq.pop_front();
                `CHK("actions", exp_act, acts)
            end
        end
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("[FAIL] watchdog expected finish seen hang");
        summarize();
    end
    initial
    begin
        void'($urandom(50));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(`REG_PTR);
        `CHK("pointer reset", 32'h0000_001F, rd_val)
        wr(`REG_HDR, 32'hFFFF_FFFF);
        rd(`REG_HDR);
        `CHK("header read only", 32'h0000_0000, rd_val)
        rd(8'h40);
        `CHK("unmapped rresp", 2'b10, rd_resp)
        wr(8'h44, 32'h0000_0001);
        `CHK("unmapped bresp", 2'b10, wr_resp)
        foreach (tbl[i])
        begin
            wr(`REG_CTRL, {28'h000_0000, tbl[i].ctrl});
            wr(`REG_SEV, {28'h000_0000, tbl[i].sev});
            wr(`REG_MASK, {28'h000_0000, tbl[i].mask});
            fire(tbl[i].kind, tbl[i].act, $urandom);
            rd(`REG_STAT);
            `CHK("status", tbl[i].st, rd_val[13:0])
            wr(`REG_STAT, 32'hFFFF_FFFF);
            rd(`REG_STAT);
            `CHK("status cleared", 14'h0000, rd_val[13:0])
        end
        // masked error leaves the pointer free for the next one
        h1 = $urandom;
        h2 = $urandom;
        wr(`REG_PTR, 32'h0000_0001);
        wr(`REG_MASK, 32'h0000_0001);
        fire(4'h0, 7'h40, h2);
        rd(`REG_PTR);
        `CHK("pointer masked", 1'b0, rd_val[5])
        wr(`REG_MASK, 32'h0000_0000);
        // loggable abort and unexpected completion together: the abort's header wins
        expq.push_back(7'h43);
        fork
            u_far.abort(abort_err_pkg::EV_POSTED_TA, h1);
            u_far.complete(3'h0, own_id, 1'b0, 1'b0, h2);
        join
        fire(4'h1, 7'h22, h2);
        rd(`REG_HDR);
        `CHK("first header kept", h1, rd_val)
        rd(`REG_PTR);
        `CHK("pointer valid", 1'b1, rd_val[5])
        wr(`REG_PTR, 32'h0000_0001);
        wr(`REG_MASK, 32'h0000_0004);
        fire(4'h5, 7'h01, h1);
        rd(`REG_PTR);
        `CHK("pointer uxc masked", 1'b0, rd_val[5])
        wr(`REG_MASK, 32'h0000_0000);
        fire(4'h5, 7'h01, h2);
        rd(`REG_HDR);
        `CHK("uxc header", h2, rd_val)
        // with the enable low an abort must leave no trace
        wr(`REG_STAT, 32'hFFFF_FFFF);
        ce <= 1'b0;
        u_far.abort(abort_err_pkg::EV_POSTED_TA, h1);
        ce <= 1'b1;
        rd(`REG_STAT);
        `CHK("frozen status", 14'h0000, rd_val[13:0])
        repeat (4) @(posedge clk);
        `CHK("pending actions", 0, expq.size())
        summarize();
    end
endmodule
`default_nettype wire
